/* File: hw/afp_csr.sv */
`timescale 1ns/10ps
`default_nettype none
`include "afp_regs.svh"

// Avalon-MM slave holding the control word and reading back status.
module afp_csr
   import afp_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        reset,
   // Avalon-MM slave.
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Block side.
   input  wire logic [31:0] status_word,
   output logic      [1:0]  mute_q
);

   logic take; // Request completes at this edge.

   assign take = (avs_read | avs_write) & ~avs_waitrequest;

   // Waitrequest drops for one cycle after each request is seen.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         avs_waitrequest <= 1'h1;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      end
   end

   // Read data is loaded as waitrequest falls and holds until the next read loads it.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         avs_readdata <= 32'h0;
      end else if (avs_read & avs_waitrequest) begin
         unique case (avs_address)
            `AFP_OFS_CTRL:   avs_readdata <= {30'h0, mute_q};
            `AFP_OFS_STATUS: avs_readdata <= status_word;
            default:         avs_readdata <= 32'h0;
         endcase
      end
   end

   // Writes land at the completing edge; unmapped writes are dropped.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mute_q <= `AFP_CTRL_RESET;
      end else if (take & avs_write & (avs_address == `AFP_OFS_CTRL)) begin
         mute_q <= avs_writedata[`AFP_CTRL_MUTE_LSB +: 2];
      end
   end

endmodule
`default_nettype wire

/* File: hw/afp_pkg.sv */
package afp_pkg;

   // Output configuration, latched once at startup.
   typedef enum logic [2:0] {
      afp_mode_bridged  = 3'h1,
      afp_mode_parallel = 3'h2,
      afp_mode_single   = 3'h4
   } afp_mode_t;

   // Startup pin short check sequence.
   typedef enum logic [4:0] {
      afp_chk_wait = 5'h01,
      afp_chk_gnd  = 5'h02,
      afp_chk_sup  = 5'h04,
      afp_chk_hold = 5'h08,
      afp_chk_run  = 5'h10
   } afp_chk_t;

   // Asynchronous inputs, carried together through the synchroniser.
   typedef struct packed {
      logic       warn;
      logic       err;
      logic       uv;
      logic [3:0] bst;
      logic [3:0] ovc;
      logic [3:0] sgnd;
      logic [3:0] ssup;
      logic       rst1_n;
      logic       rst2_n;
      logic [1:0] mode;
      logic       shut_pin;
      logic       warn_pin;
   } afp_pins_t;

endpackage

/* File: hw/afp_regs.svh */
`ifndef AFP_REGS_SVH
`define AFP_REGS_SVH

// Byte offsets of the software registers.
`define AFP_OFS_CTRL        4'h0
`define AFP_OFS_STATUS      4'h4

// Control register fields and reset value.
`define AFP_CTRL_MUTE_LSB   0
`define AFP_CTRL_RESET      2'h0

// Status register field positions.
`define AFP_ST_SHUT_POS     0
`define AFP_ST_WARN_POS     1
`define AFP_ST_OTERR_POS    2
`define AFP_ST_UV_POS       3
`define AFP_ST_OL_LSB       4
`define AFP_ST_BST_LSB      6
`define AFP_ST_MODE_LSB     10
`define AFP_ST_CHK_LSB      13
`define AFP_ST_LIM_LSB      18

// Timing: clock rate, times in their own unit, derived cycle counts.
`define AFP_CLK_MHZ         25
`define AFP_OVERLOAD_NS     10000
`define AFP_OVERLOAD_CYC    ((`AFP_OVERLOAD_NS*`AFP_CLK_MHZ+999)/1000)
`define AFP_STEP_NS         100000
`define AFP_STEP_CYC        ((`AFP_STEP_NS*`AFP_CLK_MHZ+999)/1000)
`define AFP_SETTLE_CYC      3

`endif

/* File: hw/afp_sync.sv */
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser; the first stage feeds only the second.
module afp_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         reset,
   // Data.
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q; // First stage, may go metastable.

   // Both stages clear to zero under reset.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule
`default_nettype wire

/* File: hw/afp_top.sv */
// Notes on behaviour
// - Both flags are active-low open-drain outputs.
// - Any shutdown fault pulls shutdown flag low.
// - Warning flag low while above warning threshold.
// - Flag pair encodes error, overload, warning, normal.
// - Pair reset low forces shutdown flag high.
// - Fault puts outputs Hi-Z, flag low, immediately.
// - Non-latched faults recover once condition clears.
// - Pair errors stop pair; parallel stops all.
// - Bootstrap fault stops only its half-bridge.
// - Bootstrap fault runs recharge until charged.
// - Overcurrent first limits current, no shutdown.
// - Persistent overcurrent latches overload Hi-Z shutdown.
// - Limiting and overload are independent per pair; here a reset rise on either pair clears both overload latches.
// - Pin short check only at startup.
// - Check ground shorts first, then supply shorts.
// - Short found: hold all Hi-Z until gone.
// - During check flag low, resets ignored.
// - Pair reset never restarts the check.
// - Check skipped in single-ended mode.
// - Overtemp error latches; pair reset clears.
// - Pair reset low forces that pair Hi-Z.
// - Reset rising edge clears overload latch.
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "afp_regs.svh"

module afp_top
   import afp_pkg::*;
(
   // Clock and reset.
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // Avalon-MM slave.
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Analog fault comparators, asynchronous.
   input  wire logic        overtemp_warn_in,
   input  wire logic        overtemp_error_in,
   input  wire logic        undervoltage_fault,
   input  wire logic [3:0]  bootstrap_low_fault,
   input  wire logic [3:0]  overcurrent_detect,
   input  wire logic [3:0]  short_gnd_in,
   input  wire logic [3:0]  short_supply_in,
   // Modulator controls and output configuration straps.
   input  wire logic        pair_one_reset_n,
   input  wire logic        pair_two_reset_n,
   input  wire logic [1:0]  mode_sel,
   // Open-drain status flags.
   input  wire logic        fault_shutdown_flag_n_i,
   output logic             fault_shutdown_flag_n_o,
   output logic             fault_shutdown_flag_n_oe,
   input  wire logic        overtemp_warning_flag_n_i,
   output logic             overtemp_warning_flag_n_o,
   output logic             overtemp_warning_flag_n_oe,
   // Power stage controls, half-bridges A..D in bits 0..3.
   output logic      [3:0]  half_bridge_hiz,
   output logic      [1:0]  current_limit,
   output logic      [3:0]  bootstrap_recharge,
   output logic      [1:0]  short_test_phase
);

   afp_pins_t   pin_raw;          // Inputs as they arrive.
   afp_pins_t   pin_s;            // Inputs after two flops.
   afp_mode_t   mode_q;           // Latched output configuration.
   afp_chk_t    chk_q;            // Pin short check state.
   logic [11:0] step_cnt_q;       // Time spent in the current step.
   logic [11:0] ol_cnt_q [2];     // Overcurrent persistence per pair.
   logic [1:0]  overload_fault_q; // Latched overload per pair.
   logic        overtemp_error_q; // Latched overtemperature error.
   logic        rst1_prev_q;      // Last pair one reset level.
   logic        rst2_prev_q;      // Last pair two reset level.
   logic [1:0]  mute_q;           // Software mute per pair.
   logic [31:0] status_word;      // Status register contents.
   logic        check_busy;       // Check not yet passed.
   logic        step_done;        // Current check step has run out.
   logic        wait_done;        // Strap settle time has run out.
   logic        resets_seen;      // Pair resets honoured.
   logic        rst_rise;         // Either pair reset rose.
   logic [1:0]  pair_ovc;         // Overcurrent seen in a pair.
   logic [1:0]  pair_off;         // Pair stopped by overload, mute or its reset.
   logic [1:0]  pair_rst;         // Pair held by its reset.
   logic        global_off;       // Every half-bridge must stop.
   logic        fault_any;        // Any shutdown cause.
   logic        shut_pull;        // Shutdown flag should be pulled low.
   logic        warn_pull;        // Warning flag should be pulled low.
   logic [3:0]  hiz_d;            // Next Hi-Z pattern.

   // Gather every asynchronous input into one carrier.
   assign pin_raw = '{warn: overtemp_warn_in, err: overtemp_error_in,
                      uv: undervoltage_fault, bst: bootstrap_low_fault,
                      ovc: overcurrent_detect, sgnd: short_gnd_in,
                      ssup: short_supply_in, rst1_n: pair_one_reset_n,
                      rst2_n: pair_two_reset_n, mode: mode_sel,
                      shut_pin: fault_shutdown_flag_n_i,
                      warn_pin: overtemp_warning_flag_n_i};

   // All pins cross two flops before any logic reads them.
   afp_sync #(.W($bits(afp_pins_t))) u_sync (
      .clk   (ref_clk),
      .reset (reset),
      .d     (pin_raw),
      .q     (pin_s)
   );

   // Register slave: software mute in, block state out.
   afp_csr u_csr (
      .clk             (ref_clk),
      .reset           (reset),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .status_word     (status_word),
      .mute_q          (mute_q)
   );

   // Derived conditions shared by the processes below.
   assign check_busy  = (chk_q != afp_chk_run);
   assign step_done   = (step_cnt_q == 12'(`AFP_STEP_CYC - 1));
   assign wait_done   = (step_cnt_q == 12'(`AFP_SETTLE_CYC - 1));
   assign resets_seen = ~check_busy;
   assign rst_rise    = resets_seen & ((pin_s.rst1_n & ~rst1_prev_q) |
                                       (pin_s.rst2_n & ~rst2_prev_q));
   assign pair_ovc    = {|pin_s.ovc[3:2], |pin_s.ovc[1:0]};
   assign pair_rst    = {~pin_s.rst2_n, ~pin_s.rst1_n} & {2{resets_seen}};

   // Mode straps are caught once the synchroniser has settled.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mode_q <= afp_mode_bridged;
      end else if (chk_q == afp_chk_wait && wait_done) begin
         unique case (pin_s.mode)
            2'h1:    mode_q <= afp_mode_parallel;
            2'h2:    mode_q <= afp_mode_single;
            default: mode_q <= afp_mode_bridged;
         endcase
      end
   end

   // Step timer restarts on every change of check state.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         step_cnt_q <= 12'h0;
      end else if (chk_q == afp_chk_wait) begin
         step_cnt_q <= wait_done ? 12'h0 : step_cnt_q + 12'h1;
      end else if (chk_q == afp_chk_gnd || chk_q == afp_chk_sup) begin
         step_cnt_q <= step_done ? 12'h0 : step_cnt_q + 12'h1;
      end else begin
         step_cnt_q <= 12'h0;
      end
   end

   // Startup check: ground step, supply step, then running for good.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         chk_q <= afp_chk_wait;
      end else begin
         unique case (chk_q)
            afp_chk_wait: begin
               if (wait_done) begin
                  // Single-ended strap skips the check entirely.
                  chk_q <= (pin_s.mode == 2'h2) ? afp_chk_run
                                                : afp_chk_gnd;
               end
            end
            afp_chk_gnd: begin
               if (|pin_s.sgnd) begin
                  chk_q <= afp_chk_hold;
               end else if (step_done) begin
                  chk_q <= afp_chk_sup;
               end
            end
            afp_chk_sup: begin
               if (|pin_s.ssup) begin
                  chk_q <= afp_chk_hold;
               end else if (step_done) begin
                  chk_q <= afp_chk_run;
               end
            end
            afp_chk_hold: begin
               // Startup continues only once every short is gone.
               if (~|pin_s.sgnd && ~|pin_s.ssup) begin
                  chk_q <= afp_chk_run;
               end
            end
            afp_chk_run: begin
               // Pair resets never bring the check back.
               chk_q <= afp_chk_run;
            end
            default: chk_q <= afp_chk_wait;
         endcase
      end
   end

   // Reset level history for edge detection.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rst1_prev_q <= 1'h0;
         rst2_prev_q <= 1'h0;
      end else begin
         rst1_prev_q <= pin_s.rst1_n;
         rst2_prev_q <= pin_s.rst2_n;
      end
   end

   // Overtemperature error latch; a new error beats the clear.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         overtemp_error_q <= 1'h0;
      end else if (pin_s.err) begin
         overtemp_error_q <= 1'h1;
      end else if (|pair_rst) begin
         overtemp_error_q <= 1'h0;
      end
   end

   // Per pair: count persistent overcurrent, latch overload at limit.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ol_cnt_q[0]      <= 12'h0;
         ol_cnt_q[1]      <= 12'h0;
         overload_fault_q <= 2'h0;
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (!pair_ovc[p]) begin
               ol_cnt_q[p] <= 12'h0;
            end else if (ol_cnt_q[p] != 12'(`AFP_OVERLOAD_CYC - 1)) begin
               ol_cnt_q[p] <= ol_cnt_q[p] + 12'h1;
            end
            if (pair_ovc[p] &&
                ol_cnt_q[p] == 12'(`AFP_OVERLOAD_CYC - 1)) begin
               overload_fault_q[p] <= 1'h1;
            end else if (rst_rise) begin
               overload_fault_q[p] <= 1'h0;
            end
         end
      end
   end

   // Shutdown mapping from fault sources to half-bridges.
   always_comb begin
      global_off = overtemp_error_q | pin_s.uv | check_busy;
      if (mode_q == afp_mode_parallel) begin
         pair_off = {2{|overload_fault_q}};
      end else begin
         pair_off = overload_fault_q;
      end
      pair_off = pair_off | mute_q | pair_rst;
      for (int h = 0; h < 4; h++) begin
         hiz_d[h] = global_off | pair_off[h/2] | pin_s.bst[h];
      end
      fault_any = global_off | (|overload_fault_q) | (|pin_s.bst);
      shut_pull = check_busy | (fault_any & ~|pair_rst);
      warn_pull = pin_s.warn | pin_s.err;
   end

   // Power stage outputs, registered.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         half_bridge_hiz    <= 4'hF;
         current_limit      <= 2'h0;
         bootstrap_recharge <= 4'h0;
         short_test_phase   <= 2'h0;
      end else begin
         half_bridge_hiz    <= hiz_d;
         current_limit      <= pair_ovc & ~overload_fault_q;
         bootstrap_recharge <= pin_s.bst;
         short_test_phase   <= {chk_q == afp_chk_sup,
                                chk_q == afp_chk_gnd};
      end
   end

   // Open-drain flags: enable pulls low, released otherwise.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         fault_shutdown_flag_n_o    <= 1'h0;
         fault_shutdown_flag_n_oe   <= 1'h1;
         overtemp_warning_flag_n_o  <= 1'h1;
         overtemp_warning_flag_n_oe <= 1'h0;
      end else begin
         fault_shutdown_flag_n_o    <= ~shut_pull;
         fault_shutdown_flag_n_oe   <= shut_pull;
         overtemp_warning_flag_n_o  <= ~warn_pull;
         overtemp_warning_flag_n_oe <= warn_pull;
      end
   end

   // Status word seen by software.
   always_comb begin
      status_word = 32'h0;
      status_word[`AFP_ST_SHUT_POS]     = pin_s.shut_pin;
      status_word[`AFP_ST_WARN_POS]     = pin_s.warn_pin;
      status_word[`AFP_ST_OTERR_POS]    = overtemp_error_q;
      status_word[`AFP_ST_UV_POS]       = pin_s.uv;
      status_word[`AFP_ST_OL_LSB +: 2]  = overload_fault_q;
      status_word[`AFP_ST_BST_LSB +: 4] = pin_s.bst;
      status_word[`AFP_ST_MODE_LSB +: 3] = mode_q;
      status_word[`AFP_ST_CHK_LSB +: 5] = chk_q;
      status_word[`AFP_ST_LIM_LSB +: 2] = current_limit;
   end

   // Checks on the logic above.
   sequence s_gnd_clean;
      chk_q == afp_chk_gnd && !(|pin_s.sgnd) && step_done;
   endsequence

   sequence s_sup_entered;
      chk_q == afp_chk_sup && short_test_phase == 2'h1 ##1
      short_test_phase == 2'h2;
   endsequence

   property p_ground_then_supply;
      @(posedge ref_clk) disable iff (reset)
      s_gnd_clean |=> s_sup_entered;
   endproperty
   a_ground_then_supply: assert property (p_ground_then_supply)
      else $error("supply step did not follow a clean ground step");

   property p_reset_releases_flag;
      @(posedge ref_clk) disable iff (reset)
      (!check_busy && !pin_s.rst1_n) |=> !fault_shutdown_flag_n_oe;
   endproperty
   a_reset_releases_flag: assert property (p_reset_releases_flag)
      else $error("shutdown flag pulled while a pair reset is low");

   property p_check_flag_low;
      @(posedge ref_clk) disable iff (reset)
      check_busy |=> fault_shutdown_flag_n_oe && half_bridge_hiz == 4'hF;
   endproperty
   a_check_flag_low: assert property (p_check_flag_low)
      else $error("flag or outputs released during the short check");

   property p_check_once;
      @(posedge ref_clk) disable iff (reset)
      chk_q == afp_chk_run |=> chk_q == afp_chk_run [*8];
   endproperty
   a_check_once: assert property (p_check_once)
      else $error("short check left the running state");

   property p_single_skips;
      @(posedge ref_clk) disable iff (reset)
      (chk_q == afp_chk_wait && wait_done && pin_s.mode == 2'h2)
      |=> chk_q == afp_chk_run && short_test_phase == 2'h0;
   endproperty
   a_single_skips: assert property (p_single_skips)
      else $error("short check ran in single-ended mode");

   property p_overtemp_stops_all;
      @(posedge ref_clk) disable iff (reset)
      $rose(pin_s.err) |=> overtemp_error_q ##1
      (half_bridge_hiz == 4'hF && !overtemp_warning_flag_n_o);
   endproperty
   a_overtemp_stops_all: assert property (p_overtemp_stops_all)
      else $error("overtemperature error did not stop every output");

   property p_overload_latch;
      @(posedge ref_clk) disable iff (reset)
      (pair_ovc[0] && ol_cnt_q[0] == 12'(`AFP_OVERLOAD_CYC - 1))
      |=> overload_fault_q[0] ##1 half_bridge_hiz[1:0] == 2'h3;
   endproperty
   a_overload_latch: assert property (p_overload_latch)
      else $error("persistent overcurrent did not latch overload");

   property p_limit_first;
      @(posedge ref_clk) disable iff (reset)
      (pair_ovc[0] && !overload_fault_q[0]) |=> current_limit[0];
   endproperty
   a_limit_first: assert property (p_limit_first)
      else $error("current limit not raised on overcurrent");

   property p_bootstrap_local;
      @(posedge ref_clk) disable iff (reset)
      (pin_s.bst == 4'h4 && !global_off && overload_fault_q == 2'h0 &&
       mute_q == 2'h0 && pair_rst == 2'h0)
      |=> half_bridge_hiz == 4'h4 && bootstrap_recharge == 4'h4;
   endproperty
   a_bootstrap_local: assert property (p_bootstrap_local)
      else $error("bootstrap fault stopped more than its half-bridge");

   property p_parallel_all;
      @(posedge ref_clk) disable iff (reset)
      (mode_q == afp_mode_parallel && overload_fault_q != 2'h0)
      |=> half_bridge_hiz == 4'hF;
   endproperty
   a_parallel_all: assert property (p_parallel_all)
      else $error("parallel mode error left a half-bridge running");

endmodule
`default_nettype wire

/* File: testbench/afp_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Controller side: pull-ups on both flags and paced pair reset release.
// PWM is not modelled: low time is taken as kept, so bootstrap faults
// come only from the bench's own stimulus.
module afp_ctrl_model #(
   parameter int HOLD = 40
) (
   // Clock and reset.
   input  wire logic       ref_clk,
   input  wire logic       reset,
   // Flag pulls and reset requests from the bench.
   input  wire logic       shut_oe,
   input  wire logic       warn_oe,
   input  wire logic [1:0] rst_req,
   // Resolved lines.
   output logic            shut_n,
   output logic            warn_n,
   output logic      [1:0] rst_n
);
   int   cnt;    // Cycles since the shutdown flag fell.
   logic prev_q; // Flag level one cycle ago.
   assign shut_n = ~shut_oe;
   assign warn_n = ~warn_oe;
   // A reset may rise only once HOLD cycles have passed since the flag last fell.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cnt    <= HOLD;
         prev_q <= 1'b0;
         rst_n  <= 2'h3;
      end else begin
         prev_q <= shut_n;
         if (prev_q && !shut_n) begin
            cnt <= 0;
         end else if (cnt < HOLD) begin
            cnt <= cnt + 1;
         end
         for (int i = 0; i < 2; i++) begin
            if (rst_req[i]) begin
               rst_n[i] <= 1'b0;
            end else if (cnt >= HOLD) begin
               rst_n[i] <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import afp_pkg::*;
   logic        ref_clk = 0, reset = 1, rd = 0, wr = 0;
   logic [3:0]  addr = 4'h0, bst = 4'h0, ovc = 4'h0, sg = 4'h0;
   logic [31:0] wdata = 32'h0, q;
   logic        warn_in = 0, err_in = 0, uv = 0;
   logic [1:0]  mode = 2'h0, rq = 2'h0, rst_n, lim, phase;
   logic [31:0] rdata;
   logic        wreq, shut_o, shut_oe, warn_o, warn_oe, shut_n, warn_n;
   logic [3:0]  hiz, rech;
   int          err_total = 0, total_checks = 0, cyc = 0;
   always #20 ref_clk = ~ref_clk;
   afp_top afp_top_i (.ref_clk(ref_clk), .reset(reset),
      .avs_address(addr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdata), .avs_readdata(rdata),
      .avs_waitrequest(wreq), .overtemp_warn_in(warn_in),
      .overtemp_error_in(err_in), .undervoltage_fault(uv),
      .bootstrap_low_fault(bst), .overcurrent_detect(ovc),
      .short_gnd_in(sg), .short_supply_in(sg),
      .pair_one_reset_n(rst_n[0]), .pair_two_reset_n(rst_n[1]),
      .mode_sel(mode), .fault_shutdown_flag_n_i(shut_n),
      .fault_shutdown_flag_n_o(shut_o),
      .fault_shutdown_flag_n_oe(shut_oe),
      .overtemp_warning_flag_n_i(warn_n),
      .overtemp_warning_flag_n_o(warn_o),
      .overtemp_warning_flag_n_oe(warn_oe), .half_bridge_hiz(hiz),
      .current_limit(lim), .bootstrap_recharge(rech),
      .short_test_phase(phase));
   afp_ctrl_model afp_ctrl_model_i (.ref_clk(ref_clk), .reset(reset),
      .shut_oe(shut_oe), .warn_oe(warn_oe), .rst_req(rq),
      .shut_n(shut_n), .warn_n(warn_n), .rst_n(rst_n));
   // Cuts a hung run short.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         stop_test();
      end
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // One bus access, held until waitrequest is seen low.
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a; wdata <= d; wr <= w; rd <= !w;
      do @(posedge ref_clk); while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // Reset and startup check; resets pulled low mid-check are ignored.
   task t_boot(input logic [1:0] m);
      mode <= m; reset <= 1'b1; tick(8); reset <= 1'b0; tick(20);
      if (m == 2'h2) begin
         chk("se", {phase, shut_n}, 3'h1);
      end else begin
         chk("gnd", {phase, shut_n}, 3'h2);
         rq <= 2'h3; tick(10); chk("ign", shut_n, 1'b1 ^ 1'b1);
         rq <= 2'h0; tick(2500);
         chk("sup", phase, 2'h2);
         tick(2520);
         chk("run", {phase, shut_n, hiz}, 7'h10);
         chk("run_o", {shut_o, warn_o}, 2'h3);
      end
      $display("end boot");
   endtask
   task t_faults;
      sg <= 4'hF; uv <= 1'b1; tick(6);
      chk("uv", {shut_n, warn_n, hiz}, 6'h1F);
      uv <= 1'b0; tick(6); chk("uvok", {shut_n, hiz}, 5'h10);
      sg <= 4'h0; warn_in <= 1'b1; tick(6);
      chk("warn", {shut_n, warn_n}, 2'h2);
      err_in <= 1'b1; tick(8);
      chk("ote", {shut_n, warn_n, hiz}, 6'h0F);
      chk("ote_o", {shut_o, warn_o}, 2'h0);
      err_in <= 1'b0; warn_in <= 1'b0; tick(8);
      chk("otel", {shut_n, hiz}, 5'h0F);
      rq <= 2'h1; tick(4); rq <= 2'h0; tick(60);
      chk("oteok", {shut_n, hiz, phase}, 7'h40);
      $display("end faults");
   endtask
   task t_pairs;
      rq <= 2'h1; tick(6); chk("mute", hiz, 4'h3);
      uv <= 1'b1; tick(6); chk("force", shut_n, 1'b1);
      uv <= 1'b0; rq <= 2'h0; bst <= 4'h4; tick(6);
      chk("bst", {hiz, rech}, 8'h44);
      bst <= 4'h0; ovc <= 4'h1; tick(6);
      chk("lim", {lim, hiz}, 6'h10);
      tick(260); chk("olp", {shut_n, hiz}, 5'h03);
      ovc <= 4'h0; tick(8); chk("olpl", hiz, 4'h3);
      rq <= 2'h2; tick(4); rq <= 2'h0; tick(60);
      chk("olpok", {shut_n, hiz}, 5'h10);
      $display("end pairs");
   endtask
   task t_bus;
      bus(1'b1, 4'h0, 32'h1); tick(4); chk("ctrl", hiz, 4'h3);
      bus(1'b0, 4'h0, 32'h0); chk("rctl", q, 32'h1);
      bus(1'b1, 4'h0, 32'h0); bus(1'b1, 4'h8, 32'h3);
      bus(1'b0, 4'h8, 32'h0); chk("unmap", q, 32'h0);
      bus(1'b0, 4'h4, 32'h0); chk("stat", {q[12:10], q[1:0]}, 5'h07);
      tick(4); chk("unmut", hiz, 4'h0);
      $display("end bus");
   endtask
   // Parallel boot with a short held, then overload on pair one.
   task t_par;
      mode <= 2'h1; sg <= 4'h1; reset <= 1'b1; tick(8); reset <= 1'b0;
      tick(40); chk("hold", {phase, shut_n, hiz}, 7'h0F);
      sg <= 4'h0; tick(8);
      chk("rel", {phase, shut_n, hiz}, 7'h10);
      ovc <= 4'h1; tick(262); chk("par", {shut_n, hiz}, 5'h0F);
      ovc <= 4'h0;
      $display("end par");
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      t_boot(2'h0);
      t_faults();
      t_pairs();
      t_bus();
      t_boot(2'h2);
      t_par();
      stop_test();
   end
endmodule
`default_nettype wire
